// File: hdl/scp_pkg.sv
// constants shared by the serial configuration port and its helpers
`default_nettype none
package scp_pkg;

  // ----------------------------------------------------------------
  // register addresses and reset contents
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CFG0 = 2'h0; // zero coeff, coast, rectify
  localparam logic [1:0] REG_CFG1 = 2'h1; // pole coeff, speed freq sel
  localparam logic [7:0] CFG0_RESET = 8'h98; // zero code 4, coast, rectify
  localparam logic [7:0] CFG1_RESET = 8'h73; // pole 28, freq sel 3

  // ----------------------------------------------------------------
  // frame layout, first bit shifted in lands at the top
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10; // bits per transfer
  localparam logic [4:0] HDR_BITS = 5'h08; // address, dir, five zeros
  localparam int POS_ADDR_HI = 15; // first bit, upper address bit
  localparam int POS_ADDR_LO = 14; // address_low_bit
  localparam int POS_DIR = 13; // 1 read, 0 write
  localparam int HDR_ADDR_HI = 6; // same bits after seven shifts
  localparam int HDR_ADDR_LO = 5;
  localparam int HDR_DIR = 4;

  // ----------------------------------------------------------------
  // field positions inside the two registers
  // ----------------------------------------------------------------
  localparam int POLE_LSB = 2; // filter_pole_coeff bits 7..2
  localparam int ZERO_LSB = 5; // filter_zero_coeff code bits 7..5
  localparam logic [6:0] ZERO_BASE = 7'h78; // code 0 selects 120

  // ----------------------------------------------------------------
  // program strobe timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200; // system clock rate
  localparam int PROG_HOLD_US = 5000; // least strobe high time, 5 ms
  localparam int PROG_HOLD_CYC = PROG_HOLD_US * CLK_MHZ;

endpackage
`default_nettype wire

// File: hdl/scp_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module scp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // levels from the pins and the synchronised copy
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q; // first stage, read only by the second
  logic [W-1:0] sync_q; // second stage, safe for logic

  // ----------------------------------------------------------------
  // two stages, nothing else looks at the first
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

// File: hdl/scp_nvm.sv
// the two nonvolatile configuration registers and their write port
`timescale 1ns/100ps
`default_nettype none
module scp_nvm
  import scp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // program port, one pulse per committed write
  input wire logic we_i,
  input wire logic addr_i,
  input wire logic [7:0] wdata_i,
  // stored contents
  output logic [7:0] cfg0_o,
  output logic [7:0] cfg1_o
);

  logic [7:0] mem_q [0:1]; // cell array, one word per address
  logic [7:0] mem_d [0:1];

  // ----------------------------------------------------------------
  // next contents: only the addressed word changes
  // ----------------------------------------------------------------
  always_comb begin
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    if (we_i) begin
      mem_d[addr_i] = wdata_i;
    end
  end

  // reset stands in for the factory contents of the cells
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_q[0] <= CFG0_RESET;
      mem_q[1] <= CFG1_RESET;
    end else begin
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
    end
  end

  assign cfg0_o = mem_q[0];
  assign cfg1_o = mem_q[1];

endmodule
`default_nettype wire

// File: hdl/scp_port.sv
// serial configuration port: frame receiver, read-back and programming
`timescale 1ns/100ps
`default_nettype none
// How it works
// - port live only while test mode high
// - every frame is exactly sixteen bits
// - first two bits select register address
// - third bit one reads, zero writes
// - sample serial input on clock rising edges
// - shift read data out on rising edges
// - enable rising edge opens a frame
// - strobe copies input register into cell
// - read returns contents at read time
// - test low disables port, frees pins
// - bit zero maps to last data bit
// - address one resets to 0x73
// - pole coefficient in bits seven..two
// - zero code bits seven..five, base 120
module scp_port
  import scp_pkg::*;
#(
  parameter int PROG_HOLD = PROG_HOLD_CYC // shorten in simulation
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // serial pins from the programmer
  input wire logic test_mode_i,
  input wire logic transfer_window_enable_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic prog_strobe_i,
  // serial output pin, its enable and the port active flag
  output logic so_o,
  output logic so_oe_n_o,
  output logic port_active_o,
  // configuration toward the control core
  output logic [7:0] cfg0_o,
  output logic [7:0] cfg1_o,
  output logic [5:0] filter_pole_coeff_o,
  output logic [6:0] filter_zero_coeff_o,
  output logic [1:0] speed_freq_sel_o
);

  // ----------------------------------------------------------------
  // types and local constants
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, // waiting for enable rise
    ST_SHIFT = 2'b01, // taking frame bits
    ST_FULL = 2'b10, // sixteen bits in, waiting for enable fall
    ST_BAD = 2'b11 // extra clocks, frame will be dropped
  } scp_state_t;

  localparam int PCW = $clog2(PROG_HOLD + 1);
  localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_HOLD - 1);

  // picks the addressed register for read-back
  function automatic logic [7:0] rd_sel(input logic [1:0] a,
                                        input logic [7:0] c0,
                                        input logic [7:0] c1);
    logic [7:0] r;
    r = 8'h00; // unmapped addresses read as zero
    if (a == REG_CFG0) begin
      r = c0;
    end else if (a == REG_CFG1) begin
      r = c1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge history
  // ----------------------------------------------------------------
  logic [4:0] pins_s; // test, enable, sclk, si, strobe
  logic test_s, enb_s, sclk_s, si_s, vpp_s;
  logic enb_p_q, sclk_p_q; // previous synchronised levels
  logic enb_rise, enb_fall, sclk_rise;

  scp_sync #(
    .W(5)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({test_mode_i, transfer_window_enable_i, sclk_i, si_i,
              prog_strobe_i}),
    .sync_o(pins_s)
  );

  assign {test_s, enb_s, sclk_s, si_s, vpp_s} = pins_s;
  assign enb_rise = enb_s & ~enb_p_q;
  assign enb_fall = ~enb_s & enb_p_q;
  assign sclk_rise = sclk_s & ~sclk_p_q; // the link clock is sampled

  // ----------------------------------------------------------------
  // frame and programming state
  // ----------------------------------------------------------------
  scp_state_t state_q, state_d; // frame receiver
  logic [4:0] bit_cnt_q, bit_cnt_d; // rising edges in this frame
  logic [15:0] shift_q, shift_d; // serial input register
  logic [7:0] rd_q, rd_d; // read-back shifter
  logic so_q, so_d; // serial output bit
  logic oe_n_q, oe_n_d; // output enable, low drives
  logic pend_q, pend_d; // a write waits for the strobe
  logic pend_addr_q, pend_addr_d;
  logic [7:0] pend_data_q, pend_data_d;
  logic [PCW-1:0] prog_cnt_q, prog_cnt_d; // strobe high time
  logic prog_done_q, prog_done_d; // strobe already used
  logic commit_q, commit_d; // write pulse to the cells
  logic [5:0] pole_q, pole_d;
  logic [6:0] zero_q, zero_d;
  logic [1:0] freq_q, freq_d;
  logic active_q, active_d;
  logic [7:0] cfg0, cfg1; // live cell contents
  logic [1:0] hdr_addr, frm_addr;
  logic [7:0] rd_pick; // addressed register once the header is in

  assign hdr_addr = {shift_q[HDR_ADDR_HI], shift_q[HDR_ADDR_LO]};
  assign frm_addr = {shift_q[POS_ADDR_HI], shift_q[POS_ADDR_LO]};
  assign rd_pick = rd_sel(hdr_addr, cfg0, cfg1);

  // ----------------------------------------------------------------
  // next-state logic for the whole port
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    rd_d = rd_q;
    so_d = so_q;
    oe_n_d = ~test_s;
    pend_d = pend_q;
    pend_addr_d = pend_addr_q;
    pend_data_d = pend_data_q;
    prog_cnt_d = prog_cnt_q;
    prog_done_d = prog_done_q;
    commit_d = 1'b0;
    active_d = test_s;
    // derived fields follow the cells one cycle later
    pole_d = cfg1[7:POLE_LSB];
    zero_d = ZERO_BASE + {4'h0, cfg0[7:ZERO_LSB]};
    freq_d = cfg1[1:0];

    if (!test_s) begin
      // port off: drop the frame and any waiting write
      state_d = ST_IDLE;
      bit_cnt_d = 5'h00;
      so_d = 1'b0;
      pend_d = 1'b0;
      prog_cnt_d = '0;
      prog_done_d = 1'b0;
    end else begin
      // frame receiver
      case (state_q)
        ST_IDLE: begin
          // sclk edges are ignored until the window opens
          if (enb_rise) begin
            state_d = ST_SHIFT;
            bit_cnt_d = 5'h00;
          end
        end
        ST_SHIFT: begin
          if (enb_fall) begin
            state_d = ST_IDLE; // short frame, dropped
          end else if (sclk_rise) begin
            shift_d = {shift_q[14:0], si_s};
            bit_cnt_d = bit_cnt_q + 5'h01;
            if (bit_cnt_q == HDR_BITS - 5'h01 && shift_q[HDR_DIR]) begin
              // capture now, so a fresh value reads back
              {so_d, rd_d} = {rd_pick, 1'b0};
            end else if (bit_cnt_q >= HDR_BITS) begin
              so_d = rd_q[7]; // bit zero leaves last
              rd_d = {rd_q[6:0], 1'b0};
            end
            if (bit_cnt_q == FRAME_BITS - 5'h01) begin
              state_d = ST_FULL;
            end
          end
        end
        ST_FULL: begin
          if (enb_fall) begin
            state_d = ST_IDLE;
            so_d = 1'b0;
            // a write frame to address 0 or 1 arms the cell write
            if (!shift_q[POS_DIR] && frm_addr[1] == 1'b0) begin
              pend_d = 1'b1;
              pend_addr_d = frm_addr[0];
              pend_data_d = shift_q[7:0];
            end
          end else if (sclk_rise) begin
            state_d = ST_BAD;
          end
        end
        ST_BAD: begin
          if (enb_fall) begin
            state_d = ST_IDLE;
            so_d = 1'b0;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase

      // program strobe, counted only with the window shut
      if (!vpp_s || enb_s) begin
        prog_cnt_d = '0;
        prog_done_d = 1'b0;
      end else if (!prog_done_q) begin
        prog_cnt_d = prog_cnt_q + PCW'(1);
        if (prog_cnt_q == PROG_LAST) begin
          prog_done_d = 1'b1;
          commit_d = pend_q;
          pend_d = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      rd_q <= 8'h00;
      so_q <= 1'b0;
      oe_n_q <= 1'b1;
      pend_q <= 1'b0;
      pend_addr_q <= 1'b0;
      pend_data_q <= 8'h00;
      prog_cnt_q <= '0;
      prog_done_q <= 1'b0;
      commit_q <= 1'b0;
      pole_q <= CFG1_RESET[7:POLE_LSB];
      zero_q <= ZERO_BASE + {4'h0, CFG0_RESET[7:ZERO_LSB]};
      freq_q <= CFG1_RESET[1:0];
      active_q <= 1'b0;
      enb_p_q <= 1'b0;
      sclk_p_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      rd_q <= rd_d;
      so_q <= so_d;
      oe_n_q <= oe_n_d;
      pend_q <= pend_d;
      pend_addr_q <= pend_addr_d;
      pend_data_q <= pend_data_d;
      prog_cnt_q <= prog_cnt_d;
      prog_done_q <= prog_done_d;
      commit_q <= commit_d;
      pole_q <= pole_d;
      zero_q <= zero_d;
      freq_q <= freq_d;
      active_q <= active_d;
      enb_p_q <= enb_s;
      sclk_p_q <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // configuration cells
  // ----------------------------------------------------------------
  scp_nvm u_nvm (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .we_i(commit_q),
    .addr_i(pend_addr_q),
    .wdata_i(pend_data_q),
    .cfg0_o(cfg0),
    .cfg1_o(cfg1)
  );

  assign so_o = so_q;
  assign so_oe_n_o = oe_n_q;
  assign port_active_o = active_q;
  assign cfg0_o = cfg0;
  assign cfg1_o = cfg1;
  assign filter_pole_coeff_o = pole_q;
  assign filter_zero_coeff_o = zero_q;
  assign speed_freq_sel_o = freq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_port_off: assert property (!test_s |=> oe_n_q && !pend_q)
    else $error("port still live with test mode low");
  a_cnt_clear: assert property (test_s && state_q == ST_IDLE && enb_rise
    |=> bit_cnt_q == 5'h00 && state_q == ST_SHIFT)
    else $error("enable rise did not open a clean frame");
  a_idle_clock: assert property (state_q == ST_IDLE && sclk_rise
    |=> $stable(shift_q))
    else $error("serial clock taken outside a frame");
  a_frame_len: assert property (state_q == ST_SHIFT && sclk_rise
    && bit_cnt_q == 5'h0F && test_s && !enb_fall
    |=> state_q == ST_FULL)
    else $error("sixteenth bit did not fill the frame");
  a_latch_write: assert property (test_s && state_q == ST_FULL
    && enb_fall && !shift_q[POS_DIR] && !frm_addr[1]
    |=> pend_q && pend_data_q == $past(shift_q[7:0]))
    else $error("write frame not latched at enable fall");
  a_read_first: assert property (test_s && state_q == ST_SHIFT
    && sclk_rise && !enb_fall && bit_cnt_q == 5'h07 && shift_q[HDR_DIR]
    |=> so_q == $past(rd_pick[7]))
    else $error("read-back top bit wrong");
  a_commit_cell: assert property (commit_q |=> (pend_addr_q ? cfg1 : cfg0)
    == $past(pend_data_q))
    else $error("committed value not stored");
  a_one_commit: assert property (commit_q |-> !pend_q
    ##1 !commit_q)
    else $error("second commit from one strobe");
  a_strobe_gate: assert property (enb_s |=> !commit_q)
    else $error("commit while window open");
  a_zero_map: assert property (##1 zero_q == ZERO_BASE
    + {4'h0, $past(cfg0[7:ZERO_LSB])})
    else $error("zero coefficient mapping wrong");

  c_write_commit: cover property (commit_q);
  c_read_frame: cover property (state_q == ST_FULL && shift_q[POS_DIR]);
  c_bad_frame: cover property (state_q == ST_BAD);

endmodule
`default_nettype wire

// File: sim/scp_prog_model.sv
// programmer model that drives the serial configuration pins
`timescale 1ns/100ps
`default_nettype none
module scp_prog_model (
  // bench clock, paces every pin change
  input wire logic clk_i,
  // pins toward the device
  output logic test_mode_o,
  output logic enable_o,
  output logic sclk_o,
  output logic si_o,
  output logic prog_strobe_o,
  // read-back pin from the device
  input wire logic so_i
);
  // ----------------------------------------------------------
  // idle levels; the serial clock rests low between frames except in stray_clocks
  // ----------------------------------------------------------
  initial begin
    test_mode_o = 1'b0;
    enable_o = 1'b0;
    sclk_o = 1'b0;
    si_o = 1'b0;
    prog_strobe_o = 1'b0;
  end

  // wait n falling edges, where all pins change
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // enter or leave test mode, then let the synchronisers settle
  task automatic set_test(input logic v);
    idle(1);
    test_mode_o = v;
    idle(6);
  endtask

  // one frame, first bit on top; nbits below 16 truncates it
  task automatic frame(input logic [1:0] addr, input logic rd,
                       input logic [7:0] data, input int nbits,
                       output logic [7:0] rdata);
    logic [15:0] word;
    word = {addr, rd, 5'h00, data};
    rdata = 8'h00;
    idle(1);
    enable_o = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      idle(3);
      si_o = word[15];
      // past sixteen bits only zeros follow
      word = {word[14:0], 1'b0};
      // data set up well before the rise, 125 ns period in all
      idle(10);
      sclk_o = 1'b1;
      idle(12);
      // read data is sampled just before each fall, rises 8..15
      if (i >= 7 && i <= 14) begin
        rdata[14 - i] = so_i;
      end
      sclk_o = 1'b0;
    end
    idle(6);
    enable_o = 1'b0;
    // a released data line keeps no stale value
    si_o = ~si_o;
    idle(6);
  endtask

  // program strobe, only with the frame closed
  task automatic strobe(input int n);
    idle(6);
    prog_strobe_o = 1'b1;
    idle(n);
    prog_strobe_o = 1'b0;
    idle(4);
  endtask

  // serial clock edges with enable low, which must be ignored
  task automatic stray_clocks(input int n);
    repeat (n) begin
      idle(5);
      sclk_o = 1'b1;
      idle(5);
      sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------
  // signals and settings
  // ----------------------------------------------------------
  localparam int HOLD = 20; // shortened strobe hold
  logic clk_i;
  logic nrst_i;
  logic test_mode; // pins from the model
  logic enable;
  logic sclk;
  logic si;
  logic strobe;
  logic so; // pins from the device
  logic so_oe_n;
  logic active;
  logic [7:0] cfg0;
  logic [7:0] cfg1;
  logic [5:0] pole;
  logic [6:0] zero;
  logic [1:0] fsel;
  int error_cnt = 0;
  int samples_checked = 0;

  // ----------------------------------------------------------
  // design and programmer model
  // ----------------------------------------------------------
  scp_port #(.PROG_HOLD(HOLD)) scp_port_i (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .test_mode_i(test_mode),
    .transfer_window_enable_i(enable),
    .sclk_i(sclk),
    .si_i(si),
    .prog_strobe_i(strobe),
    .so_o(so),
    .so_oe_n_o(so_oe_n),
    .port_active_o(active),
    .cfg0_o(cfg0),
    .cfg1_o(cfg1),
    .filter_pole_coeff_o(pole),
    .filter_zero_coeff_o(zero),
    .speed_freq_sel_o(fsel)
  );
  scp_prog_model scp_prog_model_i (
    .clk_i(clk_i),
    .test_mode_o(test_mode),
    .enable_o(enable),
    .sclk_o(sclk),
    .si_o(si),
    .prog_strobe_o(strobe),
    .so_i(so)
  );

  // 200 MHz clock
  initial clk_i = 1'b0;
  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------------------------
  // compare, access and report tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  // full read frame compared with the expected byte
  task automatic read_reg(input logic [1:0] a, input logic [7:0] exp,
                          input string what);
    logic [7:0] r;
    scp_prog_model_i.frame(a, 1'b1, 8'h00, 16, r);
    chk(r, exp, what);
  endtask

  // write frame of nbits, then a strobe of n cycles
  task automatic write_reg(input logic [1:0] a, input logic [7:0] d,
                           input int nbits, input int n);
    logic [7:0] r;
    scp_prog_model_i.frame(a, 1'b0, d, nbits, r);
    scp_prog_model_i.strobe(n);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the run length
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    $display("MISMATCH at %0t: run did not finish", $time);
    stop_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    // contents and pins out of reset
    chk(cfg0, scp_pkg::CFG0_RESET, "cfg0 reset");
    chk(cfg1, 8'h73, "cfg1 reset");
    chk({2'b00, pole}, 8'h1C, "pole reset");
    chk({1'b0, zero}, 8'h7C, "zero reset");
    chk({6'h00, fsel}, 8'h03, "freq reset");
    chk({7'h00, active}, 8'h00, "inactive");
    chk({7'h00, so_oe_n}, 8'h01, "so off");
    done("reset");
    // port opens, stray clocks ignored, defaults read back
    scp_prog_model_i.set_test(1'b1);
    chk({7'h00, active}, 8'h01, "active");
    chk({7'h00, so_oe_n}, 8'h00, "so on");
    scp_prog_model_i.stray_clocks(3);
    read_reg(2'h1, 8'h73, "read cfg1");
    read_reg(2'h0, scp_pkg::CFG0_RESET, "read cfg0");
    read_reg(2'h2, 8'h00, "read unmapped");
    done("read");
    // one write per frame and strobe, both mapped writes read back
    write_reg(2'h1, 8'hA5, 16, HOLD + 8);
    chk(cfg1, 8'hA5, "cfg1 write");
    chk({2'b00, pole}, 8'h29, "pole field");
    chk({6'h00, fsel}, 8'h01, "freq field");
    read_reg(2'h1, 8'hA5, "verify cfg1");
    write_reg(2'h0, 8'h6C, 16, HOLD + 8);
    chk({1'b0, zero}, 8'h7B, "zero field");
    chk(cfg1, 8'hA5, "cfg1 kept");
    read_reg(2'h0, 8'h6C, "verify cfg0");
    write_reg(2'h2, 8'h0F, 16, HOLD + 8);
    chk(cfg0, 8'h6C, "unmapped write");
    done("write");
    // short frame, short strobe and test exit all commit nothing
    write_reg(2'h1, 8'h0F, 15, HOLD + 8);
    chk(cfg1, 8'hA5, "short frame");
    write_reg(2'h1, 8'h0F, 17, HOLD + 8);
    chk(cfg1, 8'hA5, "long frame");
    write_reg(2'h1, 8'h0F, 16, HOLD / 2);
    chk(cfg1, 8'hA5, "short strobe");
    scp_prog_model_i.set_test(1'b0);
    chk({7'h00, active}, 8'h00, "exit");
    chk({7'h00, so_oe_n}, 8'h01, "so released");
    scp_prog_model_i.set_test(1'b1);
    scp_prog_model_i.strobe(HOLD + 8);
    chk(cfg1, 8'hA5, "pending dropped");
    done("refusal");
    stop_test();
  end
endmodule
`default_nettype wire
